// file: hw/tswdt_pkg.sv
// package: register map, reset values and state types of the two-stage watchdog
package tswdt_pkg;

  // register byte offsets
  localparam logic [11:0] TSWDT_OFS_RELOAD  = 12'h000;
  localparam logic [11:0] TSWDT_OFS_VALUE   = 12'h004;
  localparam logic [11:0] TSWDT_OFS_CONTROL = 12'h008;
  localparam logic [11:0] TSWDT_OFS_CLEAR   = 12'h00C;
  localparam logic [11:0] TSWDT_OFS_RAW     = 12'h010;
  localparam logic [11:0] TSWDT_OFS_MASKED  = 12'h014;
  localparam logic [11:0] TSWDT_OFS_GUARD   = 12'hC00;

  // control field positions
  localparam int TSWDT_BIT_IRQ_EN = 0;
  localparam int TSWDT_BIT_RST_EN = 1;

  // reset values and keys
  localparam logic [31:0] TSWDT_RELOAD_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] TSWDT_UNLOCK_KEY = 32'h1ACC_E551;
  localparam logic [31:0] TSWDT_ZERO       = 32'h0000_0000;
  localparam logic [31:0] TSWDT_ONE        = 32'h0000_0001;

  // counter phase: idle until armed, then counting
  typedef enum logic [0:0] {
    TSWDT_IDLE = 1'b0,
    TSWDT_RUN  = 1'b1
  } tswdt_phase_t;

  // register bus request carrier
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tswdt_bus_t;

endpackage : tswdt_pkg

// file: hw/tswdt_down_counter.sv
// file: 32-bit down counter with load and zero detect
`timescale 1ns/10ps
`default_nettype none

module tswdt_down_counter
  import tswdt_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_in,    // block clock
  input  wire logic             rst_in,    // async reset, high
  input  wire logic             run_in,    // count enable level
  input  wire logic             load_in,   // load pulse, wins over counting
  input  wire logic [WIDTH-1:0] value_in,  // value to load
  output logic      [WIDTH-1:0] count_out, // current count
  output logic                  zero_out   // counter at zero while running
);

  // counter state as one struct
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } tswdt_cnt_t;

  tswdt_cnt_t state;       // registered state
  tswdt_cnt_t next_state;  // next value

  // load wins; at zero we hold, the owner reloads
  always_comb begin
    next_state = state;
    if (load_in) begin
      next_state.count = value_in;
    end else if (run_in && (state.count != '0)) begin
      next_state.count = state.count - WIDTH'(1);
    end
  end

  // register, reset to all ones
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state.count <= '1;
    end else begin
      state <= next_state;
    end
  end

  assign count_out = state.count;
  assign zero_out  = run_in && (state.count == '0);

endmodule // tswdt_down_counter

`default_nettype wire

// file: hw/tswdt_top.sv
// file: two-stage watchdog timer, register slave and timeout logic
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module tswdt_top
  import tswdt_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic        REF_CLK_IN,      // block clock, 100 MHz
  input  wire logic        RST_IN,          // async reset, high
  input  wire logic [11:0] ADDR_IN,         // register byte address
  input  wire logic [31:0] WDATA_IN,        // write data
  input  wire logic        WR_IN,           // write strobe
  input  wire logic        RD_IN,           // read strobe
  output logic      [31:0] RDATA_OUT,       // read data, cycle after strobe
  output logic             TIMEOUT_IRQ_OUT, // timeout interrupt, masked by irq_en
  output logic             SYS_RESET_OUT    // system reset request
);

  // block state; the count lives in u_counter
  typedef struct packed {
    tswdt_phase_t     phase;        // idle or counting
    logic [WIDTH-1:0] reload;       // reload value
    logic             irq_en;       // timeout irq enable
    logic             rst_en;       // reset output enable
    logic             raw;          // pending timeout flag
    logic             locked;       // write guard state
    logic             sys_reset;    // reset request, sticky
    logic             irq;          // registered irq output
    logic [31:0]      rdata;        // registered read data
  } tswdt_state_t;

  tswdt_state_t state;       // registered state
  tswdt_state_t next_state;  // next value
  tswdt_bus_t   bus;         // bundled request

  logic             cnt_load;   // reload pulse to counter
  logic [WIDTH-1:0] cnt_value;  // value to load
  logic [WIDTH-1:0] cnt_count;  // current count
  logic             cnt_zero;   // expiry seen this cycle
  logic             wr_ok;      // write passes the guard

  assign bus.addr  = ADDR_IN;
  assign bus.wdata = WDATA_IN;
  assign bus.wr    = WR_IN;
  assign bus.rd    = RD_IN;

  // the counter itself
  tswdt_down_counter #(
    .WIDTH (WIDTH)
  ) u_counter (
    .clk_in    (REF_CLK_IN),
    .rst_in    (RST_IN),
    .run_in    (state.phase == TSWDT_RUN),
    .load_in   (cnt_load),
    .value_in  (cnt_value),
    .count_out (cnt_count),
    .zero_out  (cnt_zero)
  );

  // guard blocks writes except to the guard itself
  assign wr_ok = bus.wr && (!state.locked || bus.addr == TSWDT_OFS_GUARD);

  // next state, counter loads and read mux
  always_comb begin
    next_state = state;
    cnt_load   = 1'b0;
    cnt_value  = state.reload;
    // defaults for read data: zero unless read this cycle
    next_state.rdata = TSWDT_ZERO;

    // expiry handling
    if (cnt_zero) begin
      if (state.raw) begin
        // second expiry with flag still pending
        if (state.rst_en) begin
          next_state.sys_reset = 1'b1;
        end
      end else begin
        next_state.raw = 1'b1;
      end
      cnt_load = 1'b1;
    end

    if (wr_ok) begin
      case (bus.addr)
        TSWDT_OFS_RELOAD: begin
          // new value loads at once; flag not cleared
          next_state.reload = bus.wdata[WIDTH-1:0];
          cnt_load          = 1'b1;
          cnt_value         = bus.wdata[WIDTH-1:0];
          // zero reload flags timeout right away
          if (bus.wdata[WIDTH-1:0] == '0) begin
            next_state.raw = 1'b1;
          end
        end
        TSWDT_OFS_CONTROL: begin
          if (!state.irq_en) begin
            next_state.rst_en = bus.wdata[TSWDT_BIT_RST_EN];
            if (bus.wdata[TSWDT_BIT_IRQ_EN]) begin
              // enable arms irq and starts counting
              next_state.irq_en = 1'b1;
              next_state.phase  = TSWDT_RUN;
              // start from reload, not stale count
              cnt_load          = 1'b1;
              cnt_value         = state.reload;
            end
          end
        end
        TSWDT_OFS_CLEAR: begin
          // only register write that clears the flag
          // any value clears and reloads; resume
          // clear wins over an expiry's flag set in the same cycle, not over its reset request; the reload restarts it
          next_state.raw = 1'b0;
          cnt_load       = 1'b1;
          cnt_value      = state.reload;
        end
        TSWDT_OFS_GUARD: begin
          next_state.locked = (bus.wdata != TSWDT_UNLOCK_KEY);
        end
        default: begin
          // read-only or unmapped: write ignored
        end
      endcase
    end

    // read mux, data presented next cycle
    if (bus.rd) begin
      case (bus.addr)
        TSWDT_OFS_RELOAD:  next_state.rdata = 32'(state.reload);
        TSWDT_OFS_VALUE:   next_state.rdata = 32'(cnt_count);
        TSWDT_OFS_CONTROL: next_state.rdata = {30'h0000_0000, state.rst_en, state.irq_en};
        TSWDT_OFS_RAW:     next_state.rdata = {31'h0000_0000, state.raw};
        TSWDT_OFS_MASKED:  next_state.rdata = {31'h0000_0000, state.raw & state.irq_en};
        // lock status instead of written value
        TSWDT_OFS_GUARD:   next_state.rdata = state.locked ? TSWDT_ONE : TSWDT_ZERO;
        default:           next_state.rdata = TSWDT_ZERO;
      endcase
    end

    // irq output follows masked flag
    next_state.irq = next_state.raw & next_state.irq_en;
  end

  // reset clears enables and flag, stops, unlocks
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state.phase     <= TSWDT_IDLE;
      state.reload    <= TSWDT_RELOAD_RST;
      state.irq_en    <= 1'b0;
      state.rst_en    <= 1'b0;
      state.raw       <= 1'b0;
      state.locked    <= 1'b0;
      state.sys_reset <= 1'b0;
      state.irq       <= 1'b0;
      state.rdata     <= TSWDT_ZERO;
    end else begin
      state <= next_state;
    end
  end

  assign RDATA_OUT       = state.rdata;
  assign TIMEOUT_IRQ_OUT = state.irq;
  assign SYS_RESET_OUT   = state.sys_reset;

endmodule // tswdt_top

`default_nettype wire

// file: testbench/tswdt_top_checker.sv
// checker: port-level watchdog properties
`timescale 1ns/10ps
`default_nettype none
module tswdt_top_checker
  import tswdt_pkg::*;
#(parameter int WIDTH = 32) (
  input wire logic        REF_CLK_IN,
  input wire logic        RST_IN,
  input wire logic [11:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        TIMEOUT_IRQ_OUT,
  input wire logic        SYS_RESET_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  logic      locked;  // guard state as seen from the bus
  wire logic clr_wr = WR_IN && ADDR_IN == TSWDT_OFS_CLEAR && !locked;
  // mirror of the write guard, kept from bus traffic only
  always_ff @(posedge REF_CLK_IN or posedge RST_IN)
    if (RST_IN) locked <= 1'b0;
    else if (WR_IN && ADDR_IN == TSWDT_OFS_GUARD) locked <= WDATA_IN != TSWDT_UNLOCK_KEY;
  guard_read_a: assert property (RD_IN && ADDR_IN == TSWDT_OFS_GUARD
    |=> RDATA_OUT == {31'h0, locked}) else $error("guard read wrong");
  masked_read_a: assert property (RD_IN && ADDR_IN == TSWDT_OFS_MASKED
    |=> RDATA_OUT == {31'h0, $past(TIMEOUT_IRQ_OUT)}) else $error("masked read wrong");
  irq_hold_a: assert property (TIMEOUT_IRQ_OUT && !clr_wr |=> TIMEOUT_IRQ_OUT)
    else $error("irq dropped without clear");
  clear_drop_a: assert property (clr_wr |=> !TIMEOUT_IRQ_OUT)
    else $error("clear did not drop irq");
  reset_sticky_a: assert property (SYS_RESET_OUT |=> SYS_RESET_OUT)
    else $error("reset request released");
  reset_cause_a: assert property ($rose(SYS_RESET_OUT) |-> $past(TIMEOUT_IRQ_OUT))
    else $error("reset without pending irq");
  reset_release_a: assert property ($fell(RST_IN) |-> !TIMEOUT_IRQ_OUT && !SYS_RESET_OUT)
    else $error("outputs set after reset");
  unmapped_read_a: assert property (RD_IN && ADDR_IN == 12'h020 |=> RDATA_OUT == TSWDT_ZERO)
    else $error("unmapped read not zero");
endmodule // tswdt_top_checker
bind tswdt_top tswdt_top_checker #(.WIDTH(WIDTH)) chk_u (.REF_CLK_IN(REF_CLK_IN),
  .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .TIMEOUT_IRQ_OUT(TIMEOUT_IRQ_OUT), .SYS_RESET_OUT(SYS_RESET_OUT));
`default_nettype wire

// file: testbench/tswdt_sys_reset_model.sv
// partner: system reset logic that latches watchdog reset requests
`timescale 1ns/10ps
`default_nettype none
module tswdt_sys_reset_model (
  input  wire logic clk_in,    // system clock
  input  wire logic rst_in,    // power-on reset
  input  wire logic req_in,    // reset request from watchdog
  output logic      taken_out  // request seen since power-on
);
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) taken_out <= 1'b0;
    else if (req_in) taken_out <= 1'b1;
endmodule // tswdt_sys_reset_model
`default_nettype wire

// file: testbench/tswdt_top_tb.sv
// testbench: register-level checks of the two-stage watchdog
`timescale 1ns/10ps
`default_nettype none
module tswdt_top_tb
  import tswdt_pkg::*;
;
  logic        clk, rst, wr, rd, irq, sysrst, taken;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  int          miscompares, comparisons, cycles;
  tswdt_top #(.WIDTH(32)) dut_u (.REF_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .TIMEOUT_IRQ_OUT(irq), .SYS_RESET_OUT(sysrst));
  tswdt_sys_reset_model sys_u (.clk_in(clk), .rst_in(rst), .req_in(sysrst), .taken_out(taken));
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe, then a spare cycle so strobes never collide
  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd32(input logic [11:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge clk);
  endtask
  // bounded wait for irq (s=0) or reset request (s=1)
  task automatic wt(input bit s);
    for (int i = 0; i < 12 && (s ? sysrst : irq) !== 1'b1; i++) @(posedge clk);
  endtask
  // block clock runs before any access
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    {wr, rd, addr, wdata} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd32(TSWDT_OFS_RELOAD, TSWDT_RELOAD_RST);
    rd32(TSWDT_OFS_CONTROL, TSWDT_ZERO);
    wr32(TSWDT_OFS_RELOAD, 32'h0000_0005);
    rd32(TSWDT_OFS_VALUE, 32'h0000_0005);
    wr32(TSWDT_OFS_CONTROL, 32'h0000_0002);
    rd32(TSWDT_OFS_CONTROL, 32'h0000_0002);
    wr32(TSWDT_OFS_CONTROL, 32'h0000_0003);
    rd32(TSWDT_OFS_VALUE, 32'h0000_0004);
    wt(1'b0);
    chk({31'h0, irq}, TSWDT_ONE);
    wr32(TSWDT_OFS_RELOAD, 32'h0000_0005);
    chk({31'h0, irq}, TSWDT_ONE);
    rd32(TSWDT_OFS_RAW, TSWDT_ONE);
    wr32(TSWDT_OFS_CLEAR, 32'h0000_1234);
    chk({31'h0, irq}, TSWDT_ZERO);
    wr32(TSWDT_OFS_CONTROL, TSWDT_ZERO);
    rd32(TSWDT_OFS_CONTROL, 32'h0000_0003);
    wt(1'b0);
    chk({30'h0, sysrst, irq}, TSWDT_ONE);
    rd32(TSWDT_OFS_MASKED, TSWDT_ONE);
    wt(1'b1);
    @(posedge clk);
    chk({30'h0, taken, sysrst}, 32'h0000_0003);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    chk({30'h0, irq, sysrst}, TSWDT_ZERO);
    rd32(TSWDT_OFS_GUARD, TSWDT_ZERO);
    wr32(TSWDT_OFS_GUARD, TSWDT_ZERO);
    rd32(TSWDT_OFS_GUARD, TSWDT_ONE);
    wr32(TSWDT_OFS_RELOAD, 32'h0000_0007);
    rd32(TSWDT_OFS_RELOAD, TSWDT_RELOAD_RST);
    wr32(TSWDT_OFS_GUARD, TSWDT_UNLOCK_KEY);
    rd32(TSWDT_OFS_GUARD, TSWDT_ZERO);
    wr32(TSWDT_OFS_RELOAD, TSWDT_ZERO);
    rd32(TSWDT_OFS_RAW, TSWDT_ONE);
    rd32(TSWDT_OFS_MASKED, TSWDT_ZERO);
    rd32(12'h020, TSWDT_ZERO);
    close_out();
  end
endmodule // tswdt_top_tb
`default_nettype wire
